// ===== core/cmbt_top.sv
// CAN controller modes, wakeup, timer link, bit timing and memory map.
`timescale 1ns/1ps
`default_nettype none
module cmbt_top import cmbt_pkg::*; (
  input wire logic REF_CLK, // Module clock, 10 MHz.
  input wire logic RST_N, // Asynchronous reset, low active.
  input wire logic [6:0] ADDR, // Byte offset in window.
  input wire logic [7:0] WDATA, // Write data.
  input wire logic WR, // Write strobe.
  input wire logic RD, // Read strobe.
  output logic [7:0] RDATA, // Read data, cycle after RD.
  input wire logic STOP_MODE, // Host in stop mode.
  input wire logic CAN_RX, // Bus receive, low dominant.
  output logic CAN_TX, // Bus transmit, low dominant.
  input wire logic TX_REQ, // Engine is transmitting.
  input wire logic TX_DATA, // Next bit to send.
  output logic TX_POINT, // Transmit point strobe.
  output logic RX_BIT, // Last sampled bit.
  output logic RX_STROBE, // Sample strobe; RX_BIT takes the bit a cycle later.
  output logic BUS_SYNCED, // Bus integration done.
  input wire logic [7:0] REC, // Receive error count.
  input wire logic [7:0] TEC, // Transmit error count.
  input wire logic RXB_WE, // Receive buffer load.
  input wire logic [3:0] RXB_ADDR, // Receive buffer byte.
  input wire logic [7:0] RXB_DATA, // Receive buffer data.
  output logic WAKEUP, // Wakeup request to host.
  output logic TIMER_LINK, // Timer capture pulse.
  output logic CLOCK_SOURCE_SELECT, // High selects PLL.
  output logic [1:0] MODE // Operating mode code.
);
  logic rst_meta;
  logic rst_n;
  logic soft_reset_request;
  logic sleep_request;
  logic timer_link_enable;
  logic sleep_acknowledge;
  logic clock_source_select;
  logic wakeup_filter_select;
  logic [7:0] btr0;
  logic [7:0] btr1;
  logic [7:0] filt [0:7];
  logic [7:0] buf_mem [0:63];
  cmbt_mode_t mode;
  cmbt_mode_t next_mode;
  logic acc;
  logic wr_en;
  logic rd_en;
  logic cfg_wr;
  logic normal;
  logic asleep;
  logic wake;
  logic frame_active;
  logic frame_err;
  logic synced;
  logic run_val;
  logic [3:0] run_len;
  logic [3:0] next_len;
  logic eof_hit;
  logic tl_pend;
  logic tl_on;
  logic [7:0] next_rdata;
  cmbt_timing_if tif ();

  // Reset release through two flops; assertion stays asynchronous.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Mode decode; host wait mode is deliberately absent so nothing stalls.
  always_comb begin
    if (STOP_MODE) begin
      next_mode = CMBT_PDOWN;
    end else if (soft_reset_request) begin
      next_mode = CMBT_SOFTRST;
    end else if (sleep_acknowledge) begin
      next_mode = CMBT_SLEEP;
    end else begin
      next_mode = CMBT_NORMAL;
    end
  end

  // Mode is registered so every consumer sees one consistent value.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode <= CMBT_SOFTRST;
    end else begin
      mode <= next_mode;
    end
  end

  assign normal = (mode == CMBT_NORMAL) && !STOP_MODE && !soft_reset_request;
  assign asleep = (mode == CMBT_SLEEP) || (mode == CMBT_PDOWN);
  assign MODE = mode;

  // All clocks stop in power-down, so the port ignores every access.
  assign acc = (mode != CMBT_PDOWN) && !STOP_MODE;
  assign wr_en = WR && acc;
  assign rd_en = RD && acc;
  // Configuration is locked while the controller is on-line.
  assign cfg_wr = wr_en && (mode == CMBT_SOFTRST);

  // Control register 0: soft reset, sleep request and timer link.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_request <= CTRL0_RST[C0_SRST];
      sleep_request <= CTRL0_RST[C0_SLPRQ];
      timer_link_enable <= CTRL0_RST[C0_TLINK];
    end else if (wr_en && ADDR == OFS_CTRL0) begin
      soft_reset_request <= WDATA[C0_SRST];
      sleep_request <= WDATA[C0_SLPRQ];
      timer_link_enable <= WDATA[C0_TLINK];
    end else if (wake && mode == CMBT_SLEEP) begin
      sleep_request <= 1'b0;
    end
  end

  // Sleep is entered only between frames; bus wake or soft reset leaves.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sleep_acknowledge <= CTRL0_RST[C0_SLPACK];
    end else if (!sleep_request || soft_reset_request || wake) begin
      sleep_acknowledge <= 1'b0;
    end else if (!frame_active && !TX_REQ) begin
      sleep_acknowledge <= 1'b1;
    end
  end

  // Control register 1: clock source and wakeup filter.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      clock_source_select <= CTRL1_RST[C1_CLOCK_SOURCE_SELECT];
      wakeup_filter_select <= CTRL1_RST[C1_WFILT];
    end else if (cfg_wr && ADDR == OFS_CTRL1) begin
      clock_source_select <= WDATA[C1_CLOCK_SOURCE_SELECT];
      wakeup_filter_select <= WDATA[C1_WFILT];
    end
  end

  assign CLOCK_SOURCE_SELECT = clock_source_select;

  // Bus timing registers.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      btr0 <= BTR0_RST;
      btr1 <= BTR1_RST;
    end else if (cfg_wr) begin
      if (ADDR == OFS_BTR0) begin
        btr0 <= WDATA;
      end
      if (ADDR == OFS_BTR1) begin
        btr1 <= WDATA;
      end
    end
  end

  // Identifier filter bytes, held for the acceptance logic.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        filt[i] <= 8'h00;
      end
    end else if (cfg_wr && ADDR >= OFS_FILT && ADDR <= OFS_FILT_END) begin
      filt[ADDR[2:0]] <= WDATA;
    end
  end

  // Message buffers: receive part is loaded by the engine only.
  always_ff @(posedge REF_CLK) begin
    if (RXB_WE) begin
      buf_mem[{2'b00, RXB_ADDR}] <= RXB_DATA;
    end
    if (wr_en && ADDR >= OFS_TXBUF0) begin
      buf_mem[ADDR[5:0]] <= WDATA;
    end
  end

  // Read decode over the 128-byte window; holes read zero.
  always_comb begin
    next_rdata = 8'h00;
    if (ADDR >= OFS_RXBUF) begin
      next_rdata = buf_mem[ADDR[5:0]];
    end else if (ADDR >= OFS_FILT && ADDR <= OFS_FILT_END) begin
      next_rdata = filt[ADDR[2:0]];
    end else begin
      case (ADDR)
        OFS_CTRL0: begin
          next_rdata = {3'b000, sleep_acknowledge, 1'b0, timer_link_enable,
                        sleep_request, soft_reset_request};
        end
        OFS_CTRL1: begin
          next_rdata = {6'h00, wakeup_filter_select, clock_source_select};
        end
        OFS_BTR0: begin
          next_rdata = btr0;
        end
        OFS_BTR1: begin
          next_rdata = btr1;
        end
        OFS_STAT: begin
          next_rdata = {3'b000, frame_err, frame_active, synced, mode};
        end
        OFS_REC: begin
          next_rdata = REC;
        end
        OFS_TEC: begin
          next_rdata = TEC;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 8'h00;
    end else if (rd_en) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // Bit timing engine runs only in normal mode.
  assign tif.run = normal;
  assign tif.prescale = btr0[5:0];
  assign tif.sjw = btr0[7:6];
  assign tif.first_segment_length = btr1[3:0];
  assign tif.second_segment_length = btr1[6:4];
  assign tif.three = btr1[7];
  assign tif.idle = !frame_active;
  assign tif.rx = CAN_RX;

  cmbt_bit_timing u_timing (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .t(tif.timer)
  );

  cmbt_wake_filter #(
    .CYCLES(WAKE_CYCLES)
  ) u_wake (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .asleep(asleep),
    .filt(wakeup_filter_select),
    .rx(CAN_RX),
    .wake(wake)
  );

  assign WAKEUP = wake && (mode == CMBT_PDOWN);

  // Run length of equal sampled bits, saturating at the sync count.
  assign next_len = (tif.bit_val == run_val) ? ((run_len == SYNC_BITS) ? run_len : run_len + 4'h1) : 4'h1;
  assign eof_hit = tif.bit_val && (run_val == 1'b1) && (run_len == EOF_BITS - 4'h1);

  // The sampler's value lands one cycle after the sample strobe.
  logic smp_d;
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      smp_d <= 1'b0;
    end else begin
      smp_d <= tif.sample && normal;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      run_val <= 1'b1;
      run_len <= 4'h0;
    end else if (!normal) begin
      run_len <= 4'h0;
    end else if (smp_d) begin
      run_val <= tif.bit_val;
      run_len <= next_len;
    end
  end

  // Integration: data is ignored until 11 recessive bits are seen.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      synced <= 1'b0;
    end else if (!normal) begin
      synced <= 1'b0;
    end else if (smp_d && tif.bit_val && run_val && next_len == SYNC_BITS) begin
      synced <= 1'b1;
    end
  end

  assign BUS_SYNCED = synced;

  // Frame tracker; leaving normal mode drops a frame at once.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      frame_active <= 1'b0;
      frame_err <= 1'b0;
    end else if (!normal) begin
      frame_active <= 1'b0;
    end else if (smp_d) begin
      if (!frame_active) begin
        if (synced && !tif.bit_val) begin
          frame_active <= 1'b1;
          frame_err <= 1'b0;
        end
      end else if (eof_hit) begin
        frame_active <= 1'b0;
      end else if (!tif.bit_val && !run_val && next_len == STUFF_BITS) begin
        frame_err <= 1'b1;
      end
    end
  end

  // Pulse starts at the boundary after end of frame and lasts one bit.
  // Own frames are seen by the receiver too, so they pulse alike.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tl_pend <= 1'b0;
      tl_on <= 1'b0;
    end else if (!normal) begin
      tl_pend <= 1'b0;
      tl_on <= 1'b0;
    end else begin
      if (smp_d && frame_active && eof_hit && !frame_err) begin
        tl_pend <= 1'b1;
      end else if (tif.tx_pt) begin
        tl_pend <= 1'b0;
      end
      if (tif.tx_pt) begin
        tl_on <= tl_pend;
      end
    end
  end

  // Registered so the capture input sees one clean rising edge.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      TIMER_LINK <= 1'b0;
    end else begin
      TIMER_LINK <= tl_on && timer_link_enable;
    end
  end

  // Transmit pin: new bit at the transmit point, recessive off-line.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CAN_TX <= 1'b1;
    end else if (!normal || !synced) begin
      CAN_TX <= 1'b1;
    end else if (tif.tx_pt) begin
      CAN_TX <= TX_REQ ? TX_DATA : 1'b1;
    end
  end

  assign TX_POINT = tif.tx_pt && synced;
  assign RX_STROBE = smp_d && synced;

  // Sampled bit exposed for the protocol engine.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RX_BIT <= 1'b1;
    end else if (smp_d && synced) begin
      RX_BIT <= tif.bit_val;
    end
  end

endmodule // cmbt_top
`default_nettype wire

// ===== core/cmbt_pkg.sv
// Constants, types and helpers shared by the CAN mode and bit timing block.
// Summary of operation
// - Soft reset halts protocol, registers stay accessible.
// - Soft reset request aborts frames immediately.
// - Power-down follows host stop mode exactly.
// - Power-down entry aborts frames immediately.
// - Transmit pin recessive during power-down.
// - No register access during power-down.
// - Receive activity wakes host; data ignored.
// - Fully operational during host wait mode.
// - Optional glitch filter on receive while asleep.
// - One-bit timer pulse after valid frame.
// - Own transmitted frames also give the pulse.
// - Timer pulse gated by timer link enable.
// - Clock source select picks crystal or PLL.
// - Prescaler divides clock into time quanta.
// - Sync segment is one time quantum.
// - First segment programmable 4 to 16.
// - Second segment programmable 2 to 8.
// - Jump width programmable 1 to 4.
// - Sample at end of first segment.
// - New transmit bit at transmit point.
// - Block occupies an aligned 128-byte window.
// - Control, counters, filter, buffers at fixed offsets.
// - Mode from stop, sleep acknowledge, soft reset.
// - Wait 11 recessive bits after wakeup.
package cmbt_pkg;
  localparam logic [6:0] OFS_CTRL0 = 7'h00;
  localparam logic [6:0] OFS_CTRL1 = 7'h01;
  localparam logic [6:0] OFS_BTR0 = 7'h02;
  localparam logic [6:0] OFS_BTR1 = 7'h03;
  localparam logic [6:0] OFS_STAT = 7'h04;
  localparam logic [6:0] OFS_REC = 7'h0E;
  localparam logic [6:0] OFS_TEC = 7'h0F;
  localparam logic [6:0] OFS_FILT = 7'h10;
  localparam logic [6:0] OFS_FILT_END = 7'h17;
  localparam logic [6:0] OFS_RXBUF = 7'h40;
  localparam logic [6:0] OFS_TXBUF0 = 7'h50;
  localparam int C0_SRST = 0;
  localparam int C0_SLPRQ = 1;
  localparam int C0_TLINK = 2;
  localparam int C0_SLPACK = 4;
  localparam int C1_CLOCK_SOURCE_SELECT = 0;
  localparam int C1_WFILT = 1;
  localparam logic [7:0] CTRL0_RST = 8'h01;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] BTR0_RST = 8'h00;
  localparam logic [7:0] BTR1_RST = 8'h00;
  localparam logic [4:0] SEG1_MIN = 5'h04;
  localparam logic [4:0] SEG2_MIN = 5'h02;
  localparam logic [3:0] SYNC_BITS = 4'hB;
  localparam logic [3:0] EOF_BITS = 4'h7;
  localparam logic [3:0] STUFF_BITS = 4'h6;
  localparam int CLK_PERIOD_NS = 100;
  localparam int WAKE_GLITCH_NS = 2000;
  localparam int WAKE_CYCLES = (WAKE_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    CMBT_NORMAL = 2'b00,
    CMBT_SLEEP = 2'b01,
    CMBT_SOFTRST = 2'b11,
    CMBT_PDOWN = 2'b10
  } cmbt_mode_t;
  // Segment length with its floor applied.
  function automatic logic [4:0] seg_len(input logic [4:0] len, input logic [4:0] lo);
    seg_len = (len < lo) ? lo : len;
  endfunction
endpackage

// ===== core/cmbt_timing_if.sv
// Interface between the controller core and its bit timing engine.
`timescale 1ns/1ps
`default_nettype none
interface cmbt_timing_if;
  logic run;
  logic [5:0] prescale;
  logic [3:0] first_segment_length;
  logic [2:0] second_segment_length;
  logic [1:0] sjw;
  logic three;
  logic idle;
  logic rx;
  logic tq;
  logic sample;
  logic tx_pt;
  logic bit_val;
  modport timer (input run, prescale, first_segment_length, second_segment_length, sjw, three, idle, rx,
                 output tq, sample, tx_pt, bit_val);
  modport ctrl (output run, prescale, first_segment_length, second_segment_length, sjw, three, idle, rx,
                input tq, sample, tx_pt, bit_val);
endinterface
`default_nettype wire

// ===== core/cmbt_wake_filter.sv
// Receive-line wakeup detector with optional glitch filter.
`timescale 1ns/1ps
`default_nettype none
module cmbt_wake_filter import cmbt_pkg::*; #(
  parameter int CYCLES = WAKE_CYCLES
) (
  input wire logic clk, // Module clock.
  input wire logic rst_n, // Synchronised reset, low active.
  input wire logic asleep, // Sleep or power-down active.
  input wire logic filt, // Glitch filter selected.
  input wire logic rx, // Receive line, low is dominant.
  output logic wake // Wakeup level.
);
  logic [7:0] cnt;
  // A dominant run must last CYCLES clocks when filtering, else one clock.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
    end else if (!asleep || rx) begin
      cnt <= 8'h00;
    end else if (cnt != 8'hFF) begin
      cnt <= cnt + 8'h01;
    end
  end
  // Wake stays up until the controller leaves its low-power mode.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake <= 1'b0;
    end else if (!asleep) begin
      wake <= 1'b0;
    end else if (cnt >= (filt ? 8'(CYCLES) : 8'h01)) begin
      wake <= 1'b1;
    end
  end
endmodule // cmbt_wake_filter
`default_nettype wire

// ===== core/cmbt_bit_timing.sv
// Time quantum prescaler, bit segment counter and bus sampler.
`timescale 1ns/1ps
`default_nettype none
module cmbt_bit_timing import cmbt_pkg::*; (
  input wire logic clk, // Module clock.
  input wire logic rst_n, // Synchronised reset, low active.
  cmbt_timing_if.timer t // Configuration in, strobes out.
);
  logic [5:0] pre;
  logic [4:0] cnt;
  logic [4:0] s1;
  logic [4:0] s2;
  logic [4:0] jw;
  logic [4:0] last;
  logic rx_d;
  logic fall;
  logic [1:0] hist;
  // Field plus one gives the length; floors keep segments legal.
  assign s1 = seg_len({1'b0, t.first_segment_length} + 5'h01, SEG1_MIN);
  assign s2 = seg_len({2'b00, t.second_segment_length} + 5'h01, SEG2_MIN);
  assign jw = {3'b000, t.sjw} + 5'h01;
  assign last = s1 + s2;
  assign fall = t.run & rx_d & ~t.rx;
  assign t.tq = t.run & (pre == 6'h00);
  assign t.sample = t.tq & (cnt == s1);
  assign t.tx_pt = t.tq & (cnt == last);
  // Prescaler restarts on a hard sync so quanta align to the edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre <= 6'h00;
    end else if (!t.run || (fall && t.idle) || pre == 6'h00) begin
      pre <= t.prescale;
    end else begin
      pre <= pre - 6'h01;
    end
  end
  // Count 0 is the sync quantum; resync is bounded by the jump width.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 5'h00;
    end else if (!t.run) begin
      cnt <= 5'h00;
    end else if (fall && t.idle) begin
      cnt <= 5'h01;
    end else if (fall && cnt != 5'h00 && cnt <= s1) begin
      cnt <= (cnt > jw) ? cnt - jw : 5'h01;
    end else if (fall && cnt > s1) begin
      cnt <= (last + 5'h01 - cnt <= jw) ? 5'h01 : cnt + jw;
    end else if (t.tq) begin
      cnt <= (cnt == last) ? 5'h00 : cnt + 5'h01;
    end
  end
  // Edge detector and the two earlier quantum samples.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_d <= 1'b1;
      hist <= 2'b11;
    end else begin
      rx_d <= t.rx;
      if (t.tq) begin
        hist <= {hist[0], t.rx};
      end
    end
  end
  // Three-sample mode takes a majority, the third sample being now.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t.bit_val <= 1'b1;
    end else if (t.sample) begin
      t.bit_val <= t.three ? ((hist[1] & hist[0]) | (hist[1] & t.rx) | (hist[0] & t.rx))
                           : t.rx;
    end
  end
endmodule // cmbt_bit_timing
`default_nettype wire

// ===== verif/cmbt_can_node.sv
// Behavioural far-side bus node and transceiver for the controller bench.
`timescale 1ns/1ps
`default_nettype none
module cmbt_can_node (
  input wire logic tx, // Controller transmit, low dominant.
  input wire logic dom, // This node drives dominant.
  output logic rx // Bus level seen by the controller.
);
  // Wired-AND bus with a recessive pull-up, so a released line reads high.
  assign rx = tx & ~dom;
endmodule // cmbt_can_node
`default_nettype wire

// ===== verif/cmbt_props.sv
// Concurrent checks on the ports of the CAN mode and bit timing block.
`timescale 1ns/1ps
`default_nettype none
module cmbt_props (
  input wire logic REF_CLK, // Clock.
  input wire logic RST_N, // Reset.
  input wire logic RD, // Read.
  input wire logic [7:0] RDATA, // Data.
  input wire logic STOP_MODE, // Stop.
  input wire logic CAN_TX, // Bus out.
  input wire logic TX_POINT, // Tx point.
  input wire logic RX_BIT, // Bit.
  input wire logic RX_STROBE, // Strobe.
  input wire logic BUS_SYNCED, // Synced.
  input wire logic WAKEUP, // Wakeup.
  input wire logic TIMER_LINK, // Pulse.
  input wire logic CLOCK_SOURCE_SELECT, // Source.
  input wire logic [1:0] MODE // Mode.
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  // Stop held long enough for the mode and pin registers to follow it.
  sequence s_stop_held;
    STOP_MODE [*3];
  endsequence
  sequence s_pdown_read;
    RD && MODE == 2'b10;
  endsequence
  // A mode change may abort the bus pins just before MODE shows it.
  sequence s_leaving;
    ##[1:2] MODE != 2'b00;
  endsequence
  a_pdown_entry: assert property (STOP_MODE |-> ##[0:2] MODE == 2'b10)
    else $error("no power-down");
  a_pdown_exit: assert property ($fell(STOP_MODE) |-> ##[0:2] MODE != 2'b10)
    else $error("stuck in power-down");
  a_pdown_tx_idle: assert property (s_stop_held |-> CAN_TX)
    else $error("tx busy in power-down");
  a_pdown_no_read: assert property (s_pdown_read |=> RDATA == 8'h00)
    else $error("read in power-down");
  a_wake_in_pdown: assert property ($rose(WAKEUP) |-> MODE == 2'b10)
    else $error("stray wakeup");
  a_softrst_tx_idle: assert property (MODE == 2'b11 && $past(MODE) == 2'b11 |-> CAN_TX)
    else $error("tx busy in soft reset");
  a_clock_source_select_locked: assert property ($changed(CLOCK_SOURCE_SELECT) |-> $past(MODE) == 2'b11)
    else $error("clock source unlocked");
  a_tx_at_point: assert property ($changed(CAN_TX) && !STOP_MODE && MODE == 2'b00 |-> $past(TX_POINT) or s_leaving)
    else $error("tx off its point");
  a_rx_after_sample: assert property ($changed(RX_BIT) && MODE == 2'b00 |-> $past(RX_STROBE) or s_leaving)
    else $error("bit without strobe");
  a_link_rise_point: assert property ($rose(TIMER_LINK) |-> $past(TX_POINT, 2))
    else $error("pulse rose off boundary");
  a_link_fall_point: assert property ($fell(TIMER_LINK) && MODE == 2'b00 |-> $past(TX_POINT, 2) or s_leaving)
    else $error("pulse not one bit");
  a_sync_before_tx: assert property (!BUS_SYNCED |=> CAN_TX)
    else $error("tx before integration");
endmodule // cmbt_props
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the CAN mode and bit timing block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cmbt_pkg::*;
  logic REF_CLK, RST_N, WR, RD, STOP_MODE, TX_REQ, TX_DATA, RXB_WE, node_dom;
  logic [6:0] ADDR;
  logic [7:0] WDATA, REC, TEC, RXB_DATA, rv, w, got;
  logic [3:0] RXB_ADDR;
  wire logic CAN_RX, CAN_TX, TX_POINT, RX_BIT, RX_STROBE, BUS_SYNCED, WAKEUP, TIMER_LINK, CLOCK_SOURCE_SELECT;
  wire logic [7:0] RDATA;
  wire logic [1:0] MODE;
  int miscompares = 0;
  int checks = 0;
  int seed = 77230;
  int cyc = 0;
  int n, bitclk;
  int pre[3] = '{2, 0, 1};
  int s1[3] = '{15, 0, 3};
  int s2[3] = '{7, 0, 1};
  logic [6:0] rw_a[7] = '{OFS_FILT, OFS_FILT_END, OFS_TXBUF0, 7'h7F, 7'h09, 7'h20, 7'h3F};
  bit frame_q[$] = '{0, 1, 0, 0, 1, 0, 1, 1, 1, 1, 1, 1, 1};
  cmbt_top i_cmbt_top (.*);
  cmbt_can_node i_cmbt_can_node (.tx(CAN_TX), .dom(node_dom), .rx(CAN_RX));
  // Free-running 10 MHz module clock.
  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end
  // Cut a hang short; the whole run needs well under this many cycles.
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask
  // Read data are taken mid-cycle after the strobe.
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    @(posedge REF_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    @(negedge REF_CLK);
    got = RDATA;
    chk(got, e);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: sig = TX_POINT;
      1: sig = BUS_SYNCED;
      2: sig = RX_STROBE;
      default: sig = TIMER_LINK;
    endcase
  endfunction
  // Counts cycles until the chosen output is high.
  task automatic wait_for(input int s, input int lim);
    n = 0;
    do begin
      @(negedge REF_CLK);
      n++;
    end while (sig(s) !== 1'b1 && n < lim);
    chk(sig(s), 1'b1);
  endtask
  // One frame, sent either by the far node or by the controller's own engine.
  task automatic frame(input bit own);
    @(posedge REF_CLK);
    TX_REQ <= own;
    foreach (frame_q[k]) begin
      TX_DATA <= frame_q[k];
      wait_for(0, 400);
      @(posedge REF_CLK);
      node_dom <= !own && !frame_q[k];
      wait_for(2, 400);
      @(posedge REF_CLK);
      @(negedge REF_CLK);
      chk(RX_BIT, frame_q[k]);
      if (own)
        chk(CAN_TX, frame_q[k]);
      @(posedge REF_CLK);
    end
    TX_REQ <= 1'b0;
    node_dom <= 1'b0;
    TX_DATA <= 1'b1;
  endtask
  initial begin
    {RST_N, WR, RD, STOP_MODE, TX_REQ, RXB_WE, node_dom, ADDR, WDATA, RXB_DATA, RXB_ADDR} = '0;
    TX_DATA = 1'b1;
    rv = 8'($random(seed));
    REC = rv;
    TEC = ~rv;
    repeat (8) @(posedge REF_CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk(MODE, CMBT_SOFTRST);
    chk(CAN_TX, 1'b1);
    chk(TIMER_LINK, 1'b0);
    rdc(OFS_CTRL0, CTRL0_RST);
    rdc(OFS_CTRL1, CTRL1_RST);
    wr(OFS_REC, 8'h5A);
    rdc(OFS_REC, REC);
    rdc(OFS_TEC, TEC);
    foreach (rw_a[k]) begin
      rv = 8'($random(seed));
      wr(rw_a[k], rv);
      rdc(rw_a[k], k < 4 ? rv : 8'h00);
    end
    @(posedge REF_CLK);
    RXB_ADDR <= 4'hF;
    RXB_DATA <= rv;
    RXB_WE <= 1'b1;
    @(posedge REF_CLK);
    RXB_WE <= 1'b0;
    wr(7'h4F, ~rv);
    rdc(7'h4F, rv);
    $display("test register map done");
    // Bit timing at the segment boundaries, including clamped fields.
    for (int i = 0; i < 3; i++) begin
      bitclk = (pre[i] + 1) * (1 + (s1[i] < 3 ? 4 : s1[i] + 1) + (s2[i] < 1 ? 2 : s2[i] + 1));
      wr(OFS_CTRL0, 8'h01);
      rv = 8'(((i == 0 ? 3 : i - 1) << 6) + pre[i]);
      wr(OFS_BTR0, rv);
      rdc(OFS_BTR0, rv);
      w = 8'((i == 1 ? 128 : 0) + (s2[i] << 4) + s1[i]);
      wr(OFS_BTR1, w);
      rdc(OFS_BTR1, w);
      wr(OFS_CTRL1, 8'(2 + i % 2));
      rdc(OFS_CTRL1, 8'(2 + i % 2));
      chk(CLOCK_SOURCE_SELECT, 8'(i % 2));
      wr(OFS_CTRL0, 8'h04);
      wait_for(1, 20 * bitclk);
      chk(8'(n >= 10 * bitclk && n <= 13 * bitclk), 8'h01);
      wait_for(0, 400);
      wait_for(0, 400);
      chk(8'(n), 8'(bitclk));
    end
    wr(OFS_BTR0, 8'hFF);
    rdc(OFS_BTR0, rv);
    wr(OFS_CTRL1, 8'h01);
    rdc(OFS_CTRL1, 8'h02);
    chk(CLOCK_SOURCE_SELECT, 1'b0);
    $display("test bit timing done");
    // Timer link after received and own frames, enabled and disabled.
    for (int f = 0; f < 3; f++) begin
      wr(OFS_CTRL0, f == 1 ? 8'h00 : 8'h04);
      frame(f == 2);
      if (f == 1) begin
        w = 8'h00;
        repeat (5 * bitclk) begin
          @(negedge REF_CLK);
          w = w | TIMER_LINK;
        end
        chk(w, 8'h00);
      end else begin
        wait_for(3, 5 * bitclk);
        n = 0;
        while (TIMER_LINK === 1'b1 && n < 400) begin
          n++;
          @(negedge REF_CLK);
        end
        chk(8'(n), 8'(bitclk));
      end
    end
    $display("test timer link done");
    // Sleep handshake, then soft reset entered from sleep.
    wr(OFS_CTRL0, 8'h06);
    repeat (4) @(posedge REF_CLK);
    rdc(OFS_CTRL0, 8'h16);
    chk(MODE, CMBT_SLEEP);
    wr(OFS_CTRL0, 8'h05);
    rdc(OFS_CTRL0, 8'h05);
    chk(MODE, CMBT_SOFTRST);
    $display("test sleep done");
    // A dominant bit cut short by soft reset, then by power-down.
    for (int a = 0; a < 2; a++) begin
      wr(OFS_CTRL0, 8'h04);
      wait_for(1, 20 * bitclk);
      @(posedge REF_CLK);
      TX_REQ <= 1'b1;
      TX_DATA <= 1'b0;
      wait_for(0, 400);
      @(negedge REF_CLK);
      chk(CAN_TX, 1'b0);
      if (a == 0)
        wr(OFS_CTRL0, 8'h05);
      else
        STOP_MODE <= 1'b1;
      repeat (3) @(posedge REF_CLK);
      @(negedge REF_CLK);
      chk(CAN_TX, 1'b1);
      chk(MODE, a == 0 ? CMBT_SOFTRST : CMBT_PDOWN);
      @(posedge REF_CLK);
      TX_REQ <= 1'b0;
      TX_DATA <= 1'b1;
    end
    rdc(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL0, 8'h01);
    @(posedge REF_CLK);
    node_dom <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    node_dom <= 1'b0;
    repeat (30) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk(WAKEUP, 1'b0);
    @(posedge REF_CLK);
    node_dom <= 1'b1;
    repeat (30) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk(WAKEUP, 1'b1);
    @(posedge REF_CLK);
    node_dom <= 1'b0;
    STOP_MODE <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk(WAKEUP, 1'b0);
    chk(BUS_SYNCED, 1'b0);
    rdc(OFS_CTRL0, 8'h04);
    $display("test power-down done");
    end_sim();
  end
endmodule // tb
bind cmbt_top cmbt_props i_cmbt_props (.*);
`default_nettype wire
